// ---- dv/fmr_mem_model.sv ----
// Memory model for the resolver's read port, holding font descriptors and glyph metrics.
`timescale 1ns/1ps

module fmr_mem_model (
	input wire logic ref_clk,
	input wire logic mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic [3:0] delay,
	output logic mem_ack,
	output logic [31:0] mem_rdata
);
	logic [7:0] mb [logic [31:0]];
	logic [3:0] wait_r;

	// Assembles one aligned little-endian word; bytes never written read as zero.
	function automatic logic [31:0] rd(input logic [31:0] a);
		logic [31:0] v;
		v = 32'h0;
		for (int i = 0; i < 4; i++) begin
			if (mb.exists({a[31:2], 2'b00} + i)) begin
				v[8*i +: 8] = mb[{a[31:2], 2'b00} + i];
			end
		end
		return v;
	endfunction

	// Loaders used by the bench to place data in memory.
	task automatic put_w(input logic [31:0] a, input logic [31:0] v);
		for (int i = 0; i < 4; i++) begin
			mb[a + i] = v[8*i +: 8];
		end
	endtask

	task automatic put_b(input logic [31:0] a, input logic [7:0] v);
		mb[a] = v;
	endtask

	initial begin
		mem_ack = 1'b0;
		mem_rdata = 32'h0;
		wait_r = 4'h0;
	end

	// Answers a held read after the chosen delay; data is scrambled outside the answer cycle.
	always @(posedge ref_clk) begin
		if (mem_req && !mem_ack && wait_r >= delay) begin
			mem_ack <= 1'b1;
			mem_rdata <= rd(mem_addr);
			wait_r <= 4'h0;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_r <= (mem_req && !mem_ack) ? wait_r + 4'h1 : 4'h0;
		end
	end
endmodule // fmr_mem_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the font metrics resolver.
`timescale 1ns/1ps
`include "fmr_cfg.svh"

module tb_top;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_done = 1'b0;
	logic [11:0] cmd_read_ptr = 12'h0;
	logic [11:0] cmd_write_ptr = 12'h0;
	fmr_pkg::fmr_cmd_s font_cmd = '0;
	logic lk_req = 1'b0;
	fmr_pkg::fmr_lookup_s lk = '0;
	logic mem_ack, command_empty_interrupt, coproc_idle, lk_busy, mem_req, res_valid;
	logic [31:0] mem_rdata, mem_addr;
	logic [3:0] delay = 4'h0;
	fmr_pkg::fmr_result_s res;
	int n_mismatch = 0;
	int samples_checked = 0;

	fmr_resolver i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_done(cmd_done),
		.cmd_read_ptr(cmd_read_ptr), .cmd_write_ptr(cmd_write_ptr), .font_cmd(font_cmd),
		.lk_req(lk_req), .lk(lk), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
		.command_empty_interrupt(command_empty_interrupt), .coproc_idle(coproc_idle),
		.lk_busy(lk_busy), .mem_req(mem_req), .mem_addr(mem_addr), .res_valid(res_valid),
		.res(res));
	fmr_mem_model i_mem (.ref_clk(ref_clk), .mem_req(mem_req), .mem_addr(mem_addr),
		.delay(delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	// Clock of 100 MHz.
	always #5 ref_clk = ~ref_clk;

	// Compares one value and reports a mismatch.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic stop_test;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Issues one font command pulse.
	task automatic cmd(input logic a, input logic r, input logic g, input logic [4:0] h,
		input logic [5:0] f, input logic [31:0] p);
		@(posedge ref_clk);
		font_cmd <= '{a, r, g, h, f, p};
		@(posedge ref_clk);
		font_cmd <= '0;
		@(posedge ref_clk);
	endtask

	// Runs one lookup and compares the answer with the expected metrics.
	task automatic look(input logic [4:0] h, input logic [20:0] c, input logic err,
		input logic ext, input logic [7:0] w, input logic [31:0] fmt, input logic [31:0] ga);
		int n;
		@(posedge ref_clk);
		lk <= '{h, c};
		lk_req <= 1'b1;
		@(posedge ref_clk);
		lk_req <= 1'b0;
		#1;
		chk("lk_busy", {31'h0, lk_busy}, 32'h1);
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (res_valid !== 1'b1 && n < 300);
		chk("res_valid", {31'h0, res_valid}, 32'h1);
		chk("error", {31'h0, res.error}, {31'h0, err});
		chk("width", {24'h0, res.width}, {24'h0, w});
		chk("glyph_addr", res.glyph_addr, ga);
		if (!err) begin
			chk("extended", {31'h0, res.extended}, {31'h0, ext});
			chk("format", res.format, fmt);
			chk("in_flash", {31'h0, res.in_flash}, {31'h0, ga >= `FMR_FLASH_BASE});
		end
	endtask

	// Places the tail words of a legacy descriptor.
	task automatic leg(input logic [31:0] p, input logic [31:0] fmt, input logic [31:0] st,
		input logic [31:0] ht, input logic [31:0] base);
		i_mem.put_w(p + `FMR_LEG_FORMAT, fmt);
		i_mem.put_w(p + `FMR_LEG_STRIDE, st);
		i_mem.put_w(p + `FMR_LEG_HEIGHT, ht);
		i_mem.put_w(p + `FMR_LEG_BASE, base);
	endtask

	// Stops a hung run well beyond the expected length.
	initial begin
		#200000;
		n_mismatch++;
		stop_test();
	end

	// Main test sequence.
	initial begin
		i_mem.put_w(`FMR_FONT_ROOT_ADDR, 32'h00001000);
		leg(32'h1000, 32'h1, 32'h2, 32'h10, 32'h2000);
		i_mem.put_b(32'h1041, 8'h07);
		leg(32'h1A68, 32'h2, 32'h4, 32'h8, 32'h00900000);
		i_mem.put_b(32'h1A68 + 32'h67, 8'h09);
		i_mem.put_w(32'h4000, `FMR_EXT_SIGNATURE);
		i_mem.put_w(32'h4004, 32'h300);
		i_mem.put_w(32'h4008, 32'h25);
		i_mem.put_w(32'h4010, 32'h3);
		i_mem.put_w(32'h4014, 32'h20);
		i_mem.put_w(32'h4020, 32'h00800000);
		i_mem.put_w(32'h4024, 32'h100);
		i_mem.put_w(32'h402C, 32'h1000);
		i_mem.put_w(32'h4034, 32'h200);
		i_mem.put_b(32'h4205, 8'h0B);
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("coproc_idle", {31'h0, coproc_idle}, 32'h1);
		chk("lk_busy", {31'h0, lk_busy}, 32'h0);
		look(5'd0, 21'h41, 1'b1, 1'b0, 8'h0, 32'h0, 32'h0);
		look(5'd16, 21'h41, 1'b0, 1'b0, 8'h07, 32'h1, 32'h2000 + 2 * 16 * 'h41);
		look(5'd17, 21'h80, 1'b1, 1'b0, 8'h0, 32'h0, 32'h0);
		look(5'd18, 21'h7F, 1'b1, 1'b0, 8'h0, 32'h0, 32'h0);
		look(5'd18, 21'h1F, 1'b1, 1'b0, 8'h0, 32'h0, 32'h0);
		look(5'd5, 21'h67, 1'b1, 1'b0, 8'h0, 32'h0, 32'h0);
		cmd(1'b1, 1'b0, 1'b0, 5'd5, 6'd34, 32'h0);
		look(5'd5, 21'h67, 1'b0, 1'b0, 8'h09, 32'h2, 32'h00900000 + (4 * 8 * 'h67) / 32);
		cmd(1'b0, 1'b1, 1'b0, 5'd0, 6'd0, 32'h0);
		look(5'd5, 21'h67, 1'b1, 1'b0, 8'h0, 32'h0, 32'h0);
		cmd(1'b1, 1'b0, 1'b0, 5'd6, 6'd35, 32'h0);
		look(5'd6, 21'h41, 1'b1, 1'b0, 8'h0, 32'h0, 32'h0);
		cmd(1'b0, 1'b0, 1'b1, 5'd7, 6'd0, 32'h00800000);
		look(5'd7, 21'h41, 1'b1, 1'b0, 8'h0, 32'h0, 32'h0);
		cmd(1'b0, 1'b0, 1'b1, 5'd2, 6'd0, 32'h4000);
		delay <= 4'h2;
		look(5'd2, 21'h85, 1'b0, 1'b1, 8'h0B, 32'h25, 32'h00801000 + (3 * 32 * 5) / 32);
		look(5'd2, 21'h100, 1'b1, 1'b0, 8'h0, 32'h0, 32'h0);
		delay <= 4'h0;
		cmd(1'b0, 1'b0, 1'b1, 5'd3, 6'd0, 32'h1000);
		look(5'd3, 21'h41, 1'b0, 1'b0, 8'h07, 32'h1, 32'h2000 + 2 * 16 * 'h41);
		look(5'd3, 21'h80, 1'b1, 1'b0, 8'h0, 32'h0, 32'h0);
		@(posedge ref_clk);
		cmd_write_ptr <= 12'h10;
		cmd_done <= 1'b1;
		@(posedge ref_clk);
		cmd_done <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk("idle_busy", {31'h0, coproc_idle}, 32'h0);
		chk("irq_none", {31'h0, command_empty_interrupt}, 32'h0);
		@(posedge ref_clk);
		cmd_read_ptr <= 12'h10;
		cmd_done <= 1'b1;
		@(posedge ref_clk);
		cmd_done <= 1'b0;
		#1;
		chk("irq_pulse", {31'h0, command_empty_interrupt}, 32'h1);
		chk("idle_back", {31'h0, coproc_idle}, 32'h1);
		@(posedge ref_clk);
		#1;
		chk("irq_end", {31'h0, command_empty_interrupt}, 32'h0);
		stop_test();
	end
endmodule // tb_top

// ---- logic/fmr_resolver.sv ----
// Font metrics resolver: handle bindings, descriptor walk and command-empty event.
// What this block does
// - Pulse command-empty when the last pending command finishes executing.
// - Lookups select their font by a five-bit handle, 0 to 31.
// - Legacy descriptor is 148 bytes; first 128 bytes are per-code widths.
// - Legacy words at 128..144: format, stride, width, height, glyph pointer.
// - Built-in descriptors form a 19-entry array; root location holds its base.
// - Built-in font n descriptor lies at base plus 148 times (n-16).
// - Extended descriptor starts with signature word, size at offset 4.
// - Extended words 8..36: format, swizzle, stride, height, sizes, base, count.
// - From offset 40, one glyph offset per 128 codes, relative to base.
// - Width offset table follows, entries relative to descriptor start.
// - Width is byte at descriptor plus width offset plus code mod 128.
// - Glyph address adds stride*height*(code mod 128), divided by 32 in flash.
// - Glyph base addresses graphics RAM or flash like bitmap source.
// - After reset built-in fonts 16..31 sit on handles 16..31.
// - Fonts 32..34 need assignment; restore command brings default bindings back.
// - Built-in fonts except 17, 19 hold codes 0x20..0x7E.
// - Fonts 17 and 19 use codes 0..0x7F; host subtracts the offset.
`timescale 1ns/1ps
`include "fmr_cfg.svh"

module fmr_resolver (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic cmd_done,
	input wire logic [11:0] cmd_read_ptr,
	input wire logic [11:0] cmd_write_ptr,
	input wire fmr_pkg::fmr_cmd_s font_cmd,
	input wire logic lk_req,
	input wire fmr_pkg::fmr_lookup_s lk,
	input wire logic mem_ack,
	input wire logic [31:0] mem_rdata,
	output logic command_empty_interrupt,
	output logic coproc_idle,
	output logic lk_busy,
	output logic mem_req,
	output logic [31:0] mem_addr,
	output logic res_valid,
	output fmr_pkg::fmr_result_s res
);
	fmr_pkg::fmr_bind_s tab_r [32];
	fmr_pkg::fmr_state_e st_r, st_nxt;
	fmr_pkg::fmr_bind_s cur;
	logic [31:0] addr_nxt, mem_addr_r, desc_r, root_r, fmt_r, stride_r, height_r;
	logic [31:0] base_r, count_r, goff_r, woff_r, bpg, prod, gadd;
	logic [20:0] code_r;
	logic [7:0] width_r;
	logic err_r, err_nxt, ext_r, rom_r, mem_req_r, res_valid_r, irq_r, idle_r, busy_r;
	logic [5:0] font_r;
	fmr_pkg::fmr_result_s res_r;

	// Default binding: built-in fonts 16..31 on their own handle, rest unbound.
	function automatic fmr_pkg::fmr_bind_s default_bind(input logic [4:0] h);
		fmr_pkg::fmr_bind_s b;
		b = '0;
		b.font = {1'b0, h};
		b.bound = ({1'b0, h} >= `FMR_ROM_FIRST) && ({1'b0, h} <= `FMR_ROM_DEFAULT_LAST);
		b.rom = b.bound;
		return b;
	endfunction

	// A state that keeps a word read pending.
	function automatic logic is_read(input fmr_pkg::fmr_state_e s);
		return !(s == fmr_pkg::S_IDLE || s == fmr_pkg::S_DONE);
	endfunction

	// Code range a built-in font holds.
	function automatic logic rom_code_ok(input logic [5:0] f, input logic [20:0] c);
		if (f == `FMR_ROM_HIGH_A || f == `FMR_ROM_HIGH_B)
			return c <= `FMR_HIGH_CODE_LAST;
		return c >= `FMR_ASCII_LO && c <= `FMR_ASCII_HI;
	endfunction

	// Command-empty event and idle level from the command pointers.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_r <= 1'b0;
			idle_r <= 1'b1;
		end else begin
			irq_r <= cmd_done && (cmd_read_ptr == cmd_write_ptr);
			idle_r <= cmd_read_ptr == cmd_write_ptr;
		end
	end

	// Handle binding table, updated by the font commands.
	always_ff @(posedge ref_clk) begin
		if (sys_rst || font_cmd.restore) begin
			for (int i = 0; i < 32; i++) begin
				tab_r[i] <= default_bind(5'(i));
			end
		end else if (font_cmd.assign_rom) begin
			if (font_cmd.font >= `FMR_ROM_FIRST && font_cmd.font <= `FMR_ROM_LAST) begin
				tab_r[font_cmd.handle] <= {1'b1, 1'b1, font_cmd.font, 32'h0};
			end
		end else if (font_cmd.register_font) begin
			if (font_cmd.ptr < `FMR_FLASH_BASE) begin
				tab_r[font_cmd.handle] <= {1'b1, 1'b0, 6'h0, font_cmd.ptr};
			end
		end
	end

	assign cur = tab_r[lk.handle];

	// Walk order and address of the next descriptor word.
	always_comb begin
		st_nxt = st_r;
		addr_nxt = mem_addr_r;
		err_nxt = err_r;
		unique case (st_r)
			fmr_pkg::S_IDLE: if (lk_req) begin
				err_nxt = 1'b0;
				if (!cur.bound) begin
					err_nxt = 1'b1;
					st_nxt = fmr_pkg::S_DONE;
				end else if (cur.rom && !rom_code_ok(cur.font, lk.code)) begin
					err_nxt = 1'b1;
					st_nxt = fmr_pkg::S_DONE;
				end else if (cur.rom) begin
					st_nxt = fmr_pkg::S_ROOT;
					addr_nxt = `FMR_FONT_ROOT_ADDR;
				end else begin
					st_nxt = fmr_pkg::S_SIG;
					addr_nxt = cur.ptr;
				end
			end
			fmr_pkg::S_ROOT: if (mem_ack) begin
				st_nxt = fmr_pkg::S_SIG;
				addr_nxt = mem_rdata + 32'(`FMR_LEGACY_DESC_BYTES
					* {26'h0, font_r - `FMR_ROM_FIRST});
			end
			fmr_pkg::S_SIG: if (mem_ack) begin
				if (mem_rdata != `FMR_EXT_SIGNATURE && code_r >= `FMR_LEG_CODES) begin
					err_nxt = 1'b1;
					st_nxt = fmr_pkg::S_DONE;
				end else begin
					st_nxt = fmr_pkg::S_FMT;
					addr_nxt = desc_r + ((mem_rdata == `FMR_EXT_SIGNATURE) ?
						`FMR_EXT_FORMAT : `FMR_LEG_FORMAT);
				end
			end
			fmr_pkg::S_FMT: if (mem_ack) begin
				st_nxt = fmr_pkg::S_STRIDE;
				addr_nxt = desc_r + (ext_r ? `FMR_EXT_STRIDE : `FMR_LEG_STRIDE);
			end
			fmr_pkg::S_STRIDE: if (mem_ack) begin
				st_nxt = fmr_pkg::S_HEIGHT;
				addr_nxt = desc_r + (ext_r ? `FMR_EXT_HEIGHT : `FMR_LEG_HEIGHT);
			end
			fmr_pkg::S_HEIGHT: if (mem_ack) begin
				st_nxt = fmr_pkg::S_BASE;
				addr_nxt = desc_r + (ext_r ? `FMR_EXT_BASE : `FMR_LEG_BASE);
			end
			fmr_pkg::S_BASE: if (mem_ack) begin
				if (ext_r) begin
					st_nxt = fmr_pkg::S_COUNT;
					addr_nxt = desc_r + `FMR_EXT_COUNT;
				end else begin
					st_nxt = fmr_pkg::S_WIDTH;
					addr_nxt = desc_r + {11'h0, code_r};
				end
			end
			fmr_pkg::S_COUNT: if (mem_ack) begin
				if ({11'h0, code_r} >= mem_rdata) begin
					err_nxt = 1'b1;
					st_nxt = fmr_pkg::S_DONE;
				end else begin
					st_nxt = fmr_pkg::S_GOFF;
					addr_nxt = desc_r + `FMR_EXT_TABLE
						+ {16'h0, code_r[20:7], 2'b00};
				end
			end
			fmr_pkg::S_GOFF: if (mem_ack) begin
				st_nxt = fmr_pkg::S_WOFF;
				addr_nxt = desc_r + `FMR_EXT_TABLE + {count_r[31:2], 2'b00} / 32'h20
					+ {16'h0, code_r[20:7], 2'b00};
			end
			fmr_pkg::S_WOFF: if (mem_ack) begin
				st_nxt = fmr_pkg::S_WIDTH;
				addr_nxt = desc_r + mem_rdata + {25'h0, code_r[6:0]};
			end
			fmr_pkg::S_WIDTH: if (mem_ack) begin
				st_nxt = fmr_pkg::S_DONE;
			end
			fmr_pkg::S_DONE: st_nxt = fmr_pkg::S_IDLE;
		endcase
	end

	// State, pending read and its address.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_r <= fmr_pkg::S_IDLE;
			mem_req_r <= 1'b0;
			mem_addr_r <= 32'h0;
			err_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			mem_req_r <= is_read(st_nxt);
			mem_addr_r <= addr_nxt;
			err_r <= err_nxt;
			busy_r <= st_nxt != fmr_pkg::S_IDLE;
		end
	end

	// Fields caught from the descriptor words as they arrive.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			{desc_r, root_r, fmt_r, stride_r, height_r} <= '0;
			{base_r, count_r, goff_r, woff_r} <= '0;
			{code_r, font_r, ext_r, rom_r, width_r} <= '0;
		end else begin
			if (st_r == fmr_pkg::S_IDLE && lk_req) begin
				code_r <= lk.code;
				font_r <= cur.font;
				rom_r <= cur.rom;
				ext_r <= 1'b0;
				goff_r <= 32'h0;
			end
			if (st_nxt == fmr_pkg::S_SIG && st_r != fmr_pkg::S_SIG)
				desc_r <= addr_nxt;
			if (mem_ack) begin
				unique case (st_r)
					fmr_pkg::S_ROOT: root_r <= mem_rdata;
					fmr_pkg::S_SIG: ext_r <= mem_rdata == `FMR_EXT_SIGNATURE;
					fmr_pkg::S_FMT: fmt_r <= mem_rdata;
					fmr_pkg::S_STRIDE: stride_r <= mem_rdata;
					fmr_pkg::S_HEIGHT: height_r <= mem_rdata;
					fmr_pkg::S_BASE: base_r <= mem_rdata;
					fmr_pkg::S_COUNT: count_r <= mem_rdata;
					fmr_pkg::S_GOFF: goff_r <= mem_rdata;
					fmr_pkg::S_WOFF: woff_r <= mem_rdata;
					fmr_pkg::S_WIDTH: width_r <= mem_rdata[{mem_addr_r[1:0], 3'b000} +: 8];
					default: ;
				endcase
			end
		end
	end

	// Glyph address; flash glyphs count the product in 32-byte units.
	assign bpg = 32'(stride_r * height_r);
	assign prod = 32'(bpg * {25'h0, code_r[6:0]});
	assign gadd = base_r + goff_r + ((base_r >= `FMR_FLASH_BASE) ?
		(prod >> `FMR_FLASH_SHIFT) : prod);

	// Answer register, one pulse per lookup.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			res_valid_r <= 1'b0;
			res_r <= '0;
		end else begin
			res_valid_r <= st_r == fmr_pkg::S_DONE;
			if (st_r == fmr_pkg::S_DONE) begin
				res_r.error <= err_r;
				res_r.extended <= ext_r;
				res_r.in_flash <= base_r >= `FMR_FLASH_BASE;
				res_r.width <= err_r ? 8'h0 : width_r;
				res_r.format <= fmt_r;
				res_r.glyph_addr <= err_r ? 32'h0 : gadd;
			end
		end
	end

	assign command_empty_interrupt = irq_r;
	assign coproc_idle = idle_r;
	assign lk_busy = busy_r;
	assign mem_req = mem_req_r;
	assign mem_addr = mem_addr_r;
	assign res_valid = res_valid_r;
	assign res = res_r;

	// Checks of the walk, the bindings and the command-empty event, all on the rising clock edge.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	a_empty_irq_cause: assert property (
		command_empty_interrupt |-> $past(cmd_done) && $past(cmd_read_ptr == cmd_write_ptr))
		else $error("command-empty without a finishing command on an empty buffer");
	a_restore_defaults: assert property (
		font_cmd.restore |=> tab_r[20].bound && tab_r[20].rom && tab_r[20].font == 6'h14
			&& !tab_r[3].bound)
		else $error("restore did not give default bindings");
	a_rom_assign_bind: assert property (
		font_cmd.assign_rom && !font_cmd.restore && font_cmd.font == 6'h22
			|=> tab_r[$past(font_cmd.handle)].font == 6'h22)
		else $error("font assignment not taken");
	a_root_read_addr: assert property (
		st_r == fmr_pkg::S_ROOT |-> mem_req && mem_addr == `FMR_FONT_ROOT_ADDR)
		else $error("root pointer read at wrong address");
	a_rom_desc_addr: assert property (
		st_r == fmr_pkg::S_ROOT && mem_ack |=> st_r == fmr_pkg::S_SIG
			&& mem_addr == root_r + 32'(32'h94 * {26'h0, font_r - 6'h10}))
		else $error("built-in descriptor address wrong");
	a_sig_select: assert property (
		st_r == fmr_pkg::S_SIG && mem_ack |=> ext_r == ($past(mem_rdata) == 32'h0100AAFF))
		else $error("format choice does not follow signature");
	a_fmt_addr: assert property (
		st_r == fmr_pkg::S_FMT && mem_req |-> mem_addr == desc_r + (ext_r ? 32'h8 : 32'h80))
		else $error("format word address wrong");
	a_goff_addr: assert property (
		st_r == fmr_pkg::S_GOFF |-> mem_addr == desc_r + 32'h28 + {16'h0, code_r[20:7], 2'b00})
		else $error("glyph offset entry address wrong");
	a_width_addr: assert property (
		st_r == fmr_pkg::S_WOFF && mem_ack |=> mem_addr == desc_r + $past(mem_rdata)
			+ {25'h0, code_r[6:0]})
		else $error("width byte address wrong");
	a_rom_range: assert property (
		st_r == fmr_pkg::S_IDLE && lk_req && cur.bound && cur.rom && cur.font != 6'h11
			&& cur.font != 6'h13 && (lk.code < 21'h20 || lk.code > 21'h7E)
			|=> ##1 res_valid && res.error)
		else $error("out-of-range built-in code not refused");
	a_flash_flag: assert property (
		res_valid && !res.error |-> res.in_flash == (base_r >= 32'h00800000))
		else $error("flash flag does not follow glyph base");
	a_legacy_width_addr: assert property (
		st_r == fmr_pkg::S_BASE && mem_ack && !ext_r
			|=> mem_addr == desc_r + {11'h0, code_r})
		else $error("legacy width byte address wrong");
	a_woff_table_addr: assert property (
		st_r == fmr_pkg::S_GOFF && mem_ack |=> mem_addr == desc_r + 32'h28
			+ 32'h4 * (count_r / 32'h80) + {16'h0, code_r[20:7], 2'b00})
		else $error("width offset entry address wrong");
	a_count_refuse: assert property (
		st_r == fmr_pkg::S_COUNT && mem_ack && {11'h0, code_r} >= mem_rdata
			|=> ##1 res_valid && res.error)
		else $error("code beyond the character count not refused");
	a_reset_handles: assert property (
		$fell(sys_rst) |-> tab_r[31].bound && tab_r[31].rom && tab_r[31].font == 6'h1F
			&& !tab_r[15].bound)
		else $error("default bindings missing after reset");
	a_unbound_refuse: assert property (
		st_r == fmr_pkg::S_IDLE && lk_req && !cur.bound |=> ##1 res_valid && res.error)
		else $error("lookup on an unbound handle not refused");

	// Main scenarios that the tests should reach.
	c_ext_lookup: cover property (res_valid && res.extended && !res.error);
	c_refused: cover property (res_valid && res.error);
	c_rom_lookup: cover property (res_valid && !res.extended && rom_r && !res.error);
	c_flash_glyph: cover property (res_valid && res.in_flash);
	c_empty_irq: cover property (command_empty_interrupt);
endmodule // fmr_resolver

// ---- pkg/fmr_cfg.svh ----
// Constants of the font metrics resolver: offsets, codes and reset values.
`ifndef FMR_CFG_SVH
`define FMR_CFG_SVH
`define FMR_FONT_ROOT_ADDR 32'h002FFFFC
`define FMR_FLASH_BASE 32'h00800000
`define FMR_FLASH_SHIFT 5
`define FMR_EXT_SIGNATURE 32'h0100AAFF
`define FMR_LEGACY_DESC_BYTES 32'h94
`define FMR_LEG_FORMAT 32'h80
`define FMR_LEG_STRIDE 32'h84
`define FMR_LEG_HEIGHT 32'h8C
`define FMR_LEG_BASE 32'h90
`define FMR_EXT_FORMAT 32'h8
`define FMR_EXT_STRIDE 32'h10
`define FMR_EXT_HEIGHT 32'h14
`define FMR_EXT_BASE 32'h20
`define FMR_EXT_COUNT 32'h24
`define FMR_EXT_TABLE 32'h28
`define FMR_LEG_CODES 21'h80
`define FMR_ROM_FIRST 6'h10
`define FMR_ROM_LAST 6'h22
`define FMR_ROM_DEFAULT_LAST 6'h1F
`define FMR_ROM_HIGH_A 6'h11
`define FMR_ROM_HIGH_B 6'h13
`define FMR_ASCII_LO 21'h20
`define FMR_ASCII_HI 21'h7E
`define FMR_HIGH_CODE_LAST 21'h7F
`endif

// ---- pkg/fmr_pkg.sv ----
// Types shared by the font metrics resolver.
package fmr_pkg;
	typedef enum logic [3:0] {
		S_IDLE, S_ROOT, S_SIG, S_FMT, S_STRIDE, S_HEIGHT, S_BASE,
		S_COUNT, S_GOFF, S_WOFF, S_WIDTH, S_DONE
	} fmr_state_e;

	// One bitmap handle binding.
	typedef struct packed {
		logic bound;
		logic rom;
		logic [5:0] font;
		logic [31:0] ptr;
	} fmr_bind_s;

	// Font commands from the command parser.
	typedef struct packed {
		logic assign_rom;
		logic restore;
		logic register_font;
		logic [4:0] handle;
		logic [5:0] font;
		logic [31:0] ptr;
	} fmr_cmd_s;

	// Glyph lookup request.
	typedef struct packed {
		logic [4:0] handle;
		logic [20:0] code;
	} fmr_lookup_s;

	// Lookup answer.
	typedef struct packed {
		logic error;
		logic extended;
		logic in_flash;
		logic [7:0] width;
		logic [31:0] format;
		logic [31:0] glyph_addr;
	} fmr_result_s;
endpackage
